// ===== core/fei_pkg.sv
// Purpose: Shared constants for the fault event interrupt controller.
// Assumes: Classic Wishbone register bus with 32-bit data and byte addresses.
// Notes: Fault status and message-write fields are gathered here as well.
package fei_pkg;
  localparam int FEI_AW = 8;
  localparam logic [FEI_AW-1:0] FEI_OFF_STATUS = 8'h34;
  localparam logic [FEI_AW-1:0] FEI_OFF_CTRL = 8'h38;
  localparam logic [FEI_AW-1:0] FEI_OFF_DATA = 8'h3C;
  localparam logic [FEI_AW-1:0] FEI_OFF_ADDR = 8'h40;
  localparam logic [FEI_AW-1:0] FEI_OFF_MODE = 8'h48;
  localparam int FEI_CTRL_MASK_POS = 31;
  localparam int FEI_CTRL_PEND_POS = 30;
  localparam logic FEI_MASK_RESET = 1'b1;
  localparam logic FEI_PEND_RESET = 1'b0;
  localparam logic [31:0] FEI_DATA_RESET = 32'h0000_0000;
  localparam logic [29:0] FEI_ADDR_RESET = 30'h0000_0000;
  localparam int FEI_ST_PFO_POS = 0;
  localparam int FEI_ST_PRI_PEND_POS = 1;
  localparam int FEI_ST_AFO_POS = 2;
  localparam int FEI_ST_ADV_PEND_POS = 3;
  localparam int FEI_ST_QERR_POS = 4;
  localparam int FEI_ST_CERR_POS = 5;
  localparam int FEI_ST_TERR_POS = 6;
  localparam int FEI_ST_W = 7;
  localparam int FEI_MODE_ADV_POS = 0;
  localparam logic [31:0] FEI_UNMAPPED_READ = 32'h0000_0000;
endpackage : fei_pkg

// ===== core/fei_sync.sv
// Purpose: Two-flip-flop synchroniser for single-bit levels from outside the clock.
// Assumes: Each bit is an independent level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module fei_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule // fei_sync

// ===== core/fei_msg_tx.sv
// Purpose: Sends one posted message write and reports when it was accepted.
// Assumes: The fabric takes the write on the edge where valid and ready are both high.
// Notes: Address and data are captured at the start so later register writes cannot tear a message.
`timescale 1ns/1ps
module fei_msg_tx (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Request from the controller
  input wire logic start_in,
  input wire logic [29:0] addr_in,
  input wire logic [31:0] data_in,
  output logic busy_out,
  output logic done_out,
  // Fabric write
  output logic msg_valid_out,
  output logic [31:0] msg_addr_out,
  output logic [31:0] msg_data_out,
  input wire logic msg_ready_in
);
  wire accept = msg_valid_out && msg_ready_in;
  assign busy_out = msg_valid_out;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      msg_valid_out <= 1'b0;
      msg_addr_out <= 32'h0000_0000;
      msg_data_out <= 32'h0000_0000;
      done_out <= 1'b0;
    end else begin
      done_out <= accept;
      if (accept) begin
        msg_valid_out <= 1'b0;
      end else if (start_in && !msg_valid_out) begin
        msg_valid_out <= 1'b1;
        msg_addr_out <= {addr_in, 2'b00};
        msg_data_out <= data_in;
      end
    end
  end
endmodule // fei_msg_tx

// ===== core/fei_ctl.sv
// Purpose: Fault event interrupt controller with mask, pending bit and message registers.
// Assumes: Fault sources are asynchronous set pulses or levels arriving from the remapping logic.
// Notes: Fault recording registers live elsewhere; their fault flags arrive as a level vector.
//
// What this block does
// - Mask bit 31 resets to one; no message leaves while it is set.
// - With mask clear, a new condition sends a message using data and address registers.
// - Pending bit 30 resets zero, set when primary logging records a fault.
// - Under advanced logging, writing record zero and setting advanced flag is a condition.
// - Queue error, completion error and time-out flags each raise a condition too.
// - No new condition if any status field was already set.
// - Pending stays set while masked or transiently blocked.
// - Pending clears when the held message is actually sent.
// - Primary flag falling to zero by software clears pending without a message.
// - Write-one-to-clear of other flags; all serviced clears pending.
// - Data bits 15:0 read-write, reset zero, carried in the message.
// - Data bits 31:16 exist only with 32-bit data support, else read zero.
// - Primary flag is the OR of all recording registers' fault flags, held zero under advanced logging.
// - Address register at 040h holds dword-aligned address bits 31:2.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
module fei_ctl
  import fei_pkg::*;
#(
  parameter int NUM_RECORDS = 8,
  parameter bit DATA32 = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [FEI_AW-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Fault sources
  input wire logic [NUM_RECORDS-1:0] record_fault_in,
  input wire logic adv_record0_in,
  input wire logic adv_overflow_in,
  input wire logic primary_overflow_in,
  input wire logic inval_queue_err_in,
  input wire logic inval_completion_err_in,
  input wire logic inval_timeout_err_in,
  input wire logic transient_block_in,
  // Message write
  output logic msg_valid_out,
  output logic [31:0] msg_addr_out,
  output logic [31:0] msg_data_out,
  input wire logic msg_ready_in,
  // Status
  output logic irq_pending_out
);
  typedef enum logic [1:0] {FEI_IDLE, FEI_HOLD, FEI_SEND} fei_state_e;

  logic rst_meta_reg;
  logic rstn_sync_reg;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_reg <= 1'b0;
      rstn_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rstn_sync_reg <= rst_meta_reg;
    end
  end
  wire rstn = rstn_sync_reg;

  // Outside-domain sources pass two flip-flops before use.
  localparam int SRC_W = NUM_RECORDS + 7;
  logic [SRC_W-1:0] src_sync;
  fei_sync #(.W(SRC_W)) u_sync (
    .clk_in(clk_sys_in),
    .rstn_in(rstn),
    .d_in({transient_block_in, inval_timeout_err_in, inval_completion_err_in, inval_queue_err_in,
           primary_overflow_in, adv_overflow_in, adv_record0_in, record_fault_in}),
    .q_out(src_sync)
  );
  wire [NUM_RECORDS-1:0] rec_f = src_sync[NUM_RECORDS-1:0];
  wire adv_rec0 = src_sync[NUM_RECORDS];
  wire afo_src = src_sync[NUM_RECORDS+1];
  wire pfo_src = src_sync[NUM_RECORDS+2];
  wire qerr_src = src_sync[NUM_RECORDS+3];
  wire cerr_src = src_sync[NUM_RECORDS+4];
  wire terr_src = src_sync[NUM_RECORDS+5];
  wire blocked = src_sync[NUM_RECORDS+6];

  logic mask_reg;
  logic pend_reg;
  logic adv_mode_reg;
  logic [31:0] data_reg;
  logic [29:0] addr_reg;
  logic [FEI_ST_W-1:0] st_reg;
  logic [FEI_ST_W-1:0] st_next;
  logic pri_d_reg;
  logic adv_d_reg;
  logic qerr_d_reg;
  logic cerr_d_reg;
  logic terr_d_reg;
  fei_state_e state_reg;
  fei_state_e state_next;

  // Bus decode.
  wire req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire wr = req && wb_we_in;
  wire hit_status = wb_adr_in == FEI_OFF_STATUS;
  wire hit_ctrl = wb_adr_in == FEI_OFF_CTRL;
  wire hit_data = wb_adr_in == FEI_OFF_DATA;
  wire hit_addr = wb_adr_in == FEI_OFF_ADDR;
  wire hit_mode = wb_adr_in == FEI_OFF_MODE;
  wire [31:0] wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  wire [31:0] wbits = wb_dat_in & wmask;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // Primary flag from all recording registers.
  wire pri_pend = |rec_f;
  wire adv_edge = adv_rec0 && !adv_d_reg && adv_mode_reg;
  wire qerr_edge = qerr_src && !qerr_d_reg;
  wire cerr_edge = cerr_src && !cerr_d_reg;
  wire terr_edge = terr_src && !terr_d_reg;
  wire pri_edge = pri_pend && !pri_d_reg && !adv_mode_reg;

  // Sticky flags apart from the primary flag, which follows its level; hardware set wins over software clear.
  wire [FEI_ST_W-1:0] w1c = (wr && hit_status) ? wbits[FEI_ST_W-1:0] : '0;
  wire [FEI_ST_W-1:0] hw_set = {terr_edge, cerr_edge, qerr_edge, adv_edge, afo_src && adv_mode_reg, 1'b0,
                                pfo_src && !adv_mode_reg};
  always_comb begin
    st_next = (st_reg & ~w1c) | hw_set;
    st_next[FEI_ST_PRI_PEND_POS] = pri_pend && !adv_mode_reg;
  end
  wire any_before = |st_reg;
  wire any_after = |st_next;
  // A condition only counts when no status field was already set.
  wire new_cond = (pri_edge || adv_edge || qerr_edge || cerr_edge || terr_edge) && !any_before;
  // Everything serviced: pending drops without a message.
  wire serviced = !any_after;

  logic tx_start;
  logic tx_busy;
  logic tx_done;
  // Start once per visit to SEND; a level start would relaunch the write in the done cycle.
  assign tx_start = state_reg == FEI_SEND && !tx_busy && !tx_done;
  // Sending is allowed only with mask clear and no transient block.
  wire can_send = !mask_reg && !blocked;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FEI_IDLE: begin
        if (new_cond) begin
          state_next = FEI_HOLD;
        end
      end
      FEI_HOLD: begin
        if (serviced && !new_cond) begin
          state_next = FEI_IDLE;
        end else if (can_send) begin
          state_next = FEI_SEND;
        end
      end
      FEI_SEND: begin
        if (tx_done) begin
          state_next = FEI_IDLE;
        end
      end
    endcase
  end

  fei_msg_tx u_tx (
    .clk_in(clk_sys_in),
    .rstn_in(rstn),
    .start_in(tx_start),
    .addr_in(addr_reg),
    .data_in(data_reg),
    .busy_out(tx_busy),
    .done_out(tx_done),
    .msg_valid_out(msg_valid_out),
    .msg_addr_out(msg_addr_out),
    .msg_data_out(msg_data_out),
    .msg_ready_in(msg_ready_in)
  );

  // The pending bit tracks the held message.
  wire pend_next = state_next != FEI_IDLE;
  wire [31:0] ext_mask = DATA32 ? 32'hFFFF_FFFF : 32'h0000_FFFF;
  wire [31:0] addr_wr = merge({addr_reg, 2'b00}, wb_dat_in, wmask);
  wire [31:0] ctrl_rd = {mask_reg, pend_reg, 30'h0000_0000};
  wire [31:0] rd_mux = hit_status ? {{(32-FEI_ST_W){1'b0}}, st_reg} :
                       hit_ctrl ? ctrl_rd :
                       hit_data ? data_reg :
                       hit_addr ? {addr_reg, 2'b00} :
                       hit_mode ? {31'h0000_0000, adv_mode_reg} : FEI_UNMAPPED_READ;

  always_ff @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      state_reg <= FEI_IDLE;
      pend_reg <= FEI_PEND_RESET;
      irq_pending_out <= FEI_PEND_RESET;
      st_reg <= '0;
      pri_d_reg <= 1'b0;
      adv_d_reg <= 1'b0;
      qerr_d_reg <= 1'b0;
      cerr_d_reg <= 1'b0;
      terr_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pend_reg <= pend_next;
      irq_pending_out <= pend_next;
      st_reg <= st_next;
      pri_d_reg <= pri_pend;
      adv_d_reg <= adv_rec0;
      qerr_d_reg <= qerr_src;
      cerr_d_reg <= cerr_src;
      terr_d_reg <= terr_src;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= FEI_MASK_RESET;
      data_reg <= FEI_DATA_RESET;
      addr_reg <= FEI_ADDR_RESET;
      adv_mode_reg <= 1'b0;
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req;
      if (req) begin
        wb_dat_out <= rd_mux;
      end
      if (wr && hit_ctrl && wb_sel_in[3]) begin
        mask_reg <= wb_dat_in[FEI_CTRL_MASK_POS];
      end
      if (wr && hit_data) begin
        data_reg <= merge(data_reg, wb_dat_in, wmask & ext_mask);
      end
      if (wr && hit_addr) begin
        addr_reg <= addr_wr[31:2];
      end
      if (wr && hit_mode && wb_sel_in[0]) begin
        adv_mode_reg <= wb_dat_in[FEI_MODE_ADV_POS];
      end
    end
  end

  // Mask set keeps the message off the fabric.
  a_mask_blocks: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (state_reg == FEI_HOLD && mask_reg) |=> !(state_reg == FEI_SEND && $past(state_reg) == FEI_HOLD))
    else $error("Message started while masked.");
  a_send_unmasked: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (state_reg == FEI_HOLD && can_send && !serviced) |=> state_reg == FEI_SEND ##1 msg_valid_out)
    else $error("Unmasked condition did not send.");
  a_pend_on_cond: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (state_reg == FEI_IDLE && new_cond) |=> irq_pending_out && pend_reg)
    else $error("Pending not set on condition.");
  a_no_new_cond: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (state_reg == FEI_IDLE && any_before) |=> state_reg == FEI_IDLE)
    else $error("Condition taken with status already set.");
  a_pend_held: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (state_reg == FEI_HOLD && mask_reg && !serviced) |=> pend_reg)
    else $error("Pending dropped while masked.");
  sequence s_accept;
    msg_valid_out && msg_ready_in;
  endsequence
  a_clear_on_send: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    s_accept ##1 tx_done |=> !pend_reg)
    else $error("Pending stayed after send.");
  a_clear_serviced: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (state_reg == FEI_HOLD && serviced && !new_cond) |=> !pend_reg && !msg_valid_out)
    else $error("Serviced condition not cleared silently.");
  a_single_write: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    s_accept |=> !msg_valid_out ##1 !msg_valid_out)
    else $error("Message sent twice.");
  a_msg_payload: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    $rose(msg_valid_out) |-> msg_data_out == $past(data_reg) && msg_addr_out[1:0] == 2'b00)
    else $error("Message payload wrong.");
  a_mask_no_start: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (state_reg == FEI_HOLD && mask_reg) |=> !msg_valid_out)
    else $error("Message offered while masked.");
  a_mask_write: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (wr && hit_ctrl && wb_sel_in[3]) |=> mask_reg == $past(wb_dat_in[FEI_CTRL_MASK_POS]))
    else $error("Mask write lost.");
  a_addr_payload: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    $rose(msg_valid_out) |-> msg_addr_out == {$past(addr_reg), 2'b00})
    else $error("Message address wrong.");
  a_cond_to_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (state_reg == FEI_IDLE && pri_edge && !any_before) |=> state_reg == FEI_HOLD)
    else $error("Primary condition not held.");
  a_adv_to_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (state_reg == FEI_IDLE && adv_edge && !any_before) |=> state_reg == FEI_HOLD && pend_reg)
    else $error("Advanced condition not held.");
  a_inval_to_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (state_reg == FEI_IDLE && (qerr_edge || cerr_edge || terr_edge) && !any_before) |=> pend_reg)
    else $error("Invalidation condition not pending.");
  a_idle_no_pend: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (state_reg == FEI_IDLE && any_before) |=> !pend_reg)
    else $error("Pending set with status already set.");
  // A transient block must keep the message waiting, not drop it.
  a_block_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (state_reg == FEI_HOLD && blocked && !serviced) |=> state_reg == FEI_HOLD)
    else $error("Blocked message left hold.");
  a_pend_mirror: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    irq_pending_out == pend_reg)
    else $error("Pending output differs from pending bit.");
  a_pend_state: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    pend_reg == (state_reg != FEI_IDLE))
    else $error("Pending bit out of step with state.");
  sequence s_sent;
    s_accept ##1 tx_done;
  endsequence
  a_sent_idle: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    s_sent |=> state_reg == FEI_IDLE)
    else $error("Controller stayed busy after send.");
  a_flag_set_wins: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (|hw_set) |=> (st_reg & $past(hw_set)) == $past(hw_set))
    else $error("Hardware set lost to clear.");
  a_data_write: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (wr && hit_data && wb_sel_in == 4'hF) |=> data_reg[15:0] == $past(wb_dat_in[15:0]))
    else $error("Message data low half not written.");
  a_data_upper: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (wr && hit_data && wb_sel_in == 4'hF) |=> data_reg[31:16] == (DATA32 ? $past(wb_dat_in[31:16]) : 16'h0000))
    else $error("Message data upper half wrong.");
  a_pri_or: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    st_reg[FEI_ST_PRI_PEND_POS] == $past(pri_pend && !adv_mode_reg))
    else $error("Primary flag is not the OR of record faults.");
  a_addr_write: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    (wr && hit_addr && wb_sel_in == 4'hF) |=> addr_reg == $past(wb_dat_in[31:2]))
    else $error("Message address not written.");
  a_valid_in_send: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    s_accept |-> state_reg == FEI_SEND)
    else $error("Message taken outside send.");
  // A stalled fabric must see the same write until it takes it.
  sequence s_stall;
    msg_valid_out && !msg_ready_in;
  endsequence
  a_payload_stable: assert property (@(posedge clk_sys_in) disable iff (!rstn)
    s_stall |=> msg_valid_out && $stable(msg_data_out) && $stable(msg_addr_out))
    else $error("Message changed while stalled.");
endmodule // fei_ctl

// ===== tb/fei_fabric_model.sv
// Purpose: Fabric end that accepts message writes, promptly or after a stall.
// Assumes: A write is taken on the edge where valid and ready are both high.
// Notes: Ready stays low while nothing is offered, as a busy fabric would.
`timescale 1ns/1ps
module fei_fabric_model (
  // Clock
  input wire logic clk_in,
  // Message write
  input wire logic msg_valid_in,
  input wire logic [31:0] msg_addr_in,
  input wire logic [31:0] msg_data_in,
  output logic msg_ready_out,
  // Bench control and record
  input wire logic slow_in,
  output int count_out,
  output logic [31:0] addr_out,
  output logic [31:0] data_out
);
  int stall;
  initial begin
    msg_ready_out = 1'b0;
    count_out = 0;
    stall = 0;
    addr_out = 32'h0000_0000;
    data_out = 32'h0000_0000;
  end
  // A slow fabric stalls five cycles, so a held message must stand unchanged meanwhile.
  always @(posedge clk_in) begin
    if (msg_valid_in && msg_ready_out) begin
      count_out <= count_out + 1;
      addr_out <= msg_addr_in;
      data_out <= msg_data_in;
      msg_ready_out <= 1'b0;
      stall <= 0;
    end else if (msg_valid_in) begin
      stall <= stall + 1;
      msg_ready_out <= !slow_in || (stall >= 4);
    end else begin
      msg_ready_out <= 1'b0;
    end
  end
endmodule // fei_fabric_model

// ===== tb/fei_ctl_tb.sv
// Purpose: Self-checking bench for the fault event interrupt controller.
// Assumes: Registers are reached over classic Wishbone single cycles.
// Notes: Advanced overflow stays low; primary overflow only sets a status field and raises no condition.
`timescale 1ns/1ps
module fei_ctl_tb;
  import fei_pkg::*;
  typedef struct packed {logic [7:0] adr; logic [31:0] wd; logic [31:0] exp;} fei_row_s;
  logic clk_sys_in, rstn_in, wb_cyc, wb_stb, wb_we, wb_ack, transient, adv0, msg_valid, msg_ready, pend, slow, ovf;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat, msg_addr, msg_data, rd, last_addr, last_data;
  logic [7:0] rec;
  logic [2:0] inval;
  int n_msg, n_fail, samples_checked;
  fei_row_s rows [4];
  fei_ctl #(.NUM_RECORDS(8), .DATA32(1'b1)) dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
    .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack), .record_fault_in(rec),
    .adv_record0_in(adv0), .adv_overflow_in(1'b0), .primary_overflow_in(ovf),
    .inval_queue_err_in(inval[0]), .inval_completion_err_in(inval[1]), .inval_timeout_err_in(inval[2]),
    .transient_block_in(transient), .msg_valid_out(msg_valid), .msg_addr_out(msg_addr),
    .msg_data_out(msg_data), .msg_ready_in(msg_ready), .irq_pending_out(pend));
  fei_fabric_model fabric (.clk_in(clk_sys_in), .msg_valid_in(msg_valid), .msg_addr_in(msg_addr),
    .msg_data_in(msg_data), .msg_ready_out(msg_ready), .slow_in(slow), .count_out(n_msg),
    .addr_out(last_addr), .data_out(last_data));
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic final_report();
    $display("compared %0d, mismatched %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Software writes and reads only through here, so every access keeps the bus handshake.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] q);
    int i;
    @(posedge clk_sys_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wd;
    i = 0;
    do begin
      @(posedge clk_sys_in);
      i++;
    end while (wb_ack !== 1'b1 && i < 50);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (i >= 50) begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic wait_state(input int n, input logic p);
    int i;
    for (i = 0; i < 200 && !(n_msg == n && pend === p); i++) @(posedge clk_sys_in);
    check(n_msg, n);
    check(pend, p);
    if (i >= 200) final_report();
  endtask
  task automatic hold_state(input int n, input logic p);
    repeat (20) @(posedge clk_sys_in);
    check(n_msg, n);
    check(pend, p);
  endtask
  initial begin
    rstn_in = 1'b0;
    {wb_cyc, wb_stb, wb_we, transient, adv0, slow, ovf} = '0;
    wb_adr = 8'h00;
    wb_sel = 4'hF;
    wb_wdat = 32'h0000_0000;
    rec = 8'h00;
    inval = 3'h0;
    n_fail = 0;
    samples_checked = 0;
    rows[0] = {FEI_OFF_DATA, 32'hDEAD_BEEF, 32'hDEAD_BEEF};
    rows[1] = {FEI_OFF_ADDR, 32'h1234_5677, 32'h1234_5674};
    rows[2] = {8'h50, 32'hFFFF_FFFF, FEI_UNMAPPED_READ};
    rows[3] = {FEI_OFF_MODE, 32'h0000_0000, 32'h0000_0000};
    repeat (12) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    wb(1'b0, FEI_OFF_CTRL, 32'h0, rd);
    check(rd, 32'h8000_0000);
    wb(1'b0, FEI_OFF_DATA, 32'h0, rd);
    check(rd, FEI_DATA_RESET);
    wb(1'b0, FEI_OFF_ADDR, 32'h0, rd);
    check(rd, 32'h0000_0000);
    $display("reset values done");
    foreach (rows[k]) begin
      wb(1'b1, rows[k].adr, rows[k].wd, rd);
      wb(1'b0, rows[k].adr, 32'h0, rd);
      check(rd, rows[k].exp);
    end
    $display("register table done");
    rec <= 8'h01;
    wait_state(0, 1'b1);
    hold_state(0, 1'b1);
    wb(1'b0, FEI_OFF_CTRL, 32'h0, rd);
    check(rd, 32'hC000_0000);
    slow <= 1'b1;
    wb(1'b1, FEI_OFF_CTRL, 32'h0, rd);
    wait_state(1, 1'b0);
    check(last_addr, 32'h1234_5674);
    check(last_data, 32'hDEAD_BEEF);
    rec <= 8'h03;
    hold_state(1, 1'b0);
    $display("masked fault done");
    wb(1'b1, FEI_OFF_CTRL, 32'h8000_0000, rd);
    rec <= 8'h00;
    repeat (10) @(posedge clk_sys_in);
    rec <= 8'h80;
    wait_state(1, 1'b1);
    rec <= 8'h00;
    wait_state(1, 1'b0);
    wb(1'b1, FEI_OFF_CTRL, 32'h0, rd);
    hold_state(1, 1'b0);
    $display("primary service done");
    for (int k = 0; k < 3; k++) begin
      inval[k] <= 1'b1;
      wait_state(2 + k, 1'b0);
      inval[k] <= 1'b0;
      wb(1'b1, FEI_OFF_STATUS, 32'h1 << (FEI_ST_QERR_POS + k), rd);
      wb(1'b0, FEI_OFF_STATUS, 32'h0, rd);
      check(rd, 32'h0000_0000);
    end
    $display("invalidation errors done");
    transient <= 1'b1;
    inval[0] <= 1'b1;
    wait_state(4, 1'b1);
    hold_state(4, 1'b1);
    transient <= 1'b0;
    wait_state(5, 1'b0);
    wb(1'b1, FEI_OFF_STATUS, 32'h1 << FEI_ST_QERR_POS, rd);
    $display("transient block done");
    wb(1'b1, FEI_OFF_CTRL, 32'h8000_0000, rd);
    inval[1] <= 1'b1;
    wait_state(5, 1'b1);
    wb(1'b1, FEI_OFF_STATUS, 32'h1 << FEI_ST_CERR_POS, rd);
    wait_state(5, 1'b0);
    wb(1'b1, FEI_OFF_CTRL, 32'h0, rd);
    hold_state(5, 1'b0);
    $display("status service done");
    ovf <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    inval[2] <= 1'b1;
    hold_state(5, 1'b0);
    wb(1'b0, FEI_OFF_STATUS, 32'h0, rd);
    check(rd, (32'h1 << FEI_ST_TERR_POS) | (32'h1 << FEI_ST_PFO_POS));
    ovf <= 1'b0;
    inval[2] <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    wb(1'b1, FEI_OFF_STATUS, (32'h1 << FEI_ST_TERR_POS) | (32'h1 << FEI_ST_PFO_POS), rd);
    $display("overflow block done");
    wb(1'b1, FEI_OFF_MODE, 32'h1, rd);
    adv0 <= 1'b1;
    wait_state(6, 1'b0);
    wb(1'b1, FEI_OFF_STATUS, 32'h1 << FEI_ST_ADV_PEND_POS, rd);
    wb(1'b0, FEI_OFF_STATUS, 32'h0, rd);
    check(rd, 32'h0000_0000);
    $display("advanced logging done");
    final_report();
  end
endmodule // fei_ctl_tb
